// ==== core/rcel_top.sv ====
// Reset-time configuration loader: serial ROM reader, manual pin control, strap capture
// How it works
// R1: After reset the loader clocks the serial ROM with the system clock divided by 256.
// R2: With manual control on, the serial clock pin follows a software-set bit.
// R3: Chip select is driven active high, so the ROM is selected only while it is high.
// R4: The automatic read runs only if the board holds chip select high; otherwise it is skipped.
// R5: With manual control on, chip select follows a software-set bit.
// R6: Write data goes out on its own pin and software can set its level directly.
// R7: Read data comes in on its own pin and software can read its level.
// R8: After hard or soft reset the half-duplex strap goes to feature bit 5 of all 8 channels.
// R9: The infrared strap is caught after hard or soft reset into modem bit 6 of all 8 channels.
// R10: The system reset input is active low and must be high for normal operation.
// R11: Loaded words are handed out as address and data for the identification values.
// R12: Manual control freezes the automatic clock and sequence and drives pins from the bits.
`timescale 1ns/1ps
`default_nettype none
module rcel_top
  import rcel_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic soft_reset_i,
  // Manual control bits
  input wire logic manual_en_i,
  input wire logic manual_clk_i,
  input wire logic manual_cs_i,
  input wire logic manual_wdata_i,
  output logic manual_rdata_o,
  output logic manual_clk_level_o,
  // Serial ROM pins
  input wire logic rom_serial_clock_i,
  output logic rom_serial_clock_o,
  output logic rom_serial_clock_oe_n_o,
  input wire logic rom_chip_select_i,
  output logic rom_chip_select_o,
  output logic rom_chip_select_oe_n_o,
  output logic rom_write_data_o,
  input wire logic rom_read_data_i,
  // Straps
  input wire logic auto_halfduplex_strap_n_i,
  input wire logic infrared_strap_n_i,
  // Per-channel strap images
  output logic [UART_CHANNELS-1:0][7:0] uart_feature_control_o,
  output logic [UART_CHANNELS-1:0][7:0] uart_modem_control_o,
  // Loaded word stream and status
  output logic word_valid_o,
  output rcel_word_s word_o,
  input wire logic word_ready_i,
  output logic load_busy_o,
  output logic load_done_o,
  output logic load_skipped_o
);
  // Reset release through two flip-flops
  logic rst_meta_r, rst_n_r;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin // R10
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // Strap capture: armed by reset, retaken on soft reset
  logic strap_arm_r, strap_arm_nxt;
  logic [UART_CHANNELS-1:0] hd_r, hd_nxt, ir_r, ir_nxt;
  always_comb begin
    strap_arm_nxt = soft_reset_i;
    hd_nxt = hd_r;
    ir_nxt = ir_r;
    if (strap_arm_r) begin
      hd_nxt = {UART_CHANNELS{~auto_halfduplex_strap_n_i}}; // R8
      ir_nxt = {UART_CHANNELS{~infrared_strap_n_i}}; // R9
    end
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      strap_arm_r <= 1'b1;
      hd_r <= '0;
      ir_r <= '0;
    end else begin
      strap_arm_r <= strap_arm_nxt;
      hd_r <= hd_nxt;
      ir_r <= ir_nxt;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < UART_CHANNELS; ch++) begin : g_chan
      always_comb begin
        uart_feature_control_o[ch] = 8'h00;
        uart_feature_control_o[ch][FEATURE_HALFDUPLEX_BIT] = hd_r[ch]; // R8
        uart_modem_control_o[ch] = 8'h00;
        uart_modem_control_o[ch][MODEM_INFRARED_BIT] = ir_r[ch]; // R9
      end
    end
  endgenerate

  // Automatic read sequencer
  rcel_state_e st_r, st_nxt;
  logic [6:0] div_r, div_nxt;
  logic [2:0] sense_r, sense_nxt;
  logic [4:0] bit_r, bit_nxt;
  logic [5:0] addr_r, addr_nxt;
  logic [8:0] cmd_r, cmd_nxt;
  logic [15:0] data_r, data_nxt;
  logic sck_r, sck_nxt, cs_r, cs_nxt, cs_oe_n_r, cs_oe_n_nxt, di_r, di_nxt;
  logic sck_oe_n_r;
  logic skip_r, skip_nxt;
  logic done_r, done_nxt, busy_r, busy_nxt;
  logic mrd_r, mclk_r;
  logic buf_ready;
  logic tick;
  rcel_word_s push_word;

  assign tick = (div_r == ROM_HALF_LAST);
  assign push_word = '{addr: addr_r, data: data_r};

  always_comb begin
    st_nxt = st_r;
    div_nxt = div_r;
    sense_nxt = sense_r;
    bit_nxt = bit_r;
    addr_nxt = addr_r;
    cmd_nxt = cmd_r;
    data_nxt = data_r;
    sck_nxt = sck_r;
    cs_nxt = cs_r;
    cs_oe_n_nxt = cs_oe_n_r;
    di_nxt = di_r;
    skip_nxt = skip_r;
    if (soft_reset_i) begin
      st_nxt = ST_SENSE;
      sense_nxt = 3'h0;
      sck_nxt = 1'b0;
      cs_nxt = 1'b0;
      cs_oe_n_nxt = 1'b1;
      di_nxt = 1'b0;
      skip_nxt = 1'b0;
    end else if (manual_en_i) begin
      // Sequence and divider hold still while software owns the pins
      sck_nxt = manual_clk_i; // R12 R2
      cs_nxt = manual_cs_i; // R12 R5
      cs_oe_n_nxt = 1'b0;
      di_nxt = manual_wdata_i; // R6
    end else begin
      div_nxt = tick ? 7'h00 : div_r + 7'h01; // R1
      unique case (st_r)
        ST_SENSE: begin
          // Pin is released so the board strap alone sets its level
          cs_oe_n_nxt = 1'b1;
          sense_nxt = sense_r + 3'h1;
          if (sense_r == ROM_SENSE_LAST) begin
            if (rom_chip_select_i) begin // R4
              st_nxt = ST_SHIFT;
              addr_nxt = ROM_ADDR_RST;
              bit_nxt = 5'h00;
              cmd_nxt = {ROM_READ_CMD[1:0], ROM_ADDR_RST, 1'b0};
              di_nxt = ROM_READ_CMD[2];
              cs_nxt = 1'b1; // R3
              cs_oe_n_nxt = 1'b0;
              div_nxt = 7'h00;
            end else begin
              st_nxt = ST_DONE;
              skip_nxt = 1'b1;
              cs_nxt = 1'b0;
            end
          end
        end
        ST_SHIFT: begin
          if (tick && !sck_r) begin
            sck_nxt = 1'b1; // R1
            if (bit_r >= ROM_CMD_BITS) begin
              data_nxt = {data_r[14:0], rom_read_data_i}; // R7
            end
          end else if (tick) begin
            sck_nxt = 1'b0;
            if (bit_r == ROM_FRAME_LAST) begin
              st_nxt = ST_PUSH;
            end else begin
              bit_nxt = bit_r + 5'h01;
              di_nxt = cmd_r[8]; // R6
              cmd_nxt = {cmd_r[7:0], 1'b0};
            end
          end
        end
        ST_PUSH: begin
          // Clock stays low while the buffer is full
          div_nxt = 7'h00;
          if (buf_ready) begin // R11
            st_nxt = ST_GAP;
            cs_nxt = 1'b0; // R3
          end
        end
        ST_GAP: begin
          if (tick) begin
            if (addr_r == ROM_LAST_ADDR) begin
              st_nxt = ST_DONE;
            end else begin
              st_nxt = ST_SHIFT;
              addr_nxt = addr_r + 6'h01;
              bit_nxt = 5'h00;
              cmd_nxt = {ROM_READ_CMD[1:0], addr_r + 6'h01, 1'b0};
              di_nxt = ROM_READ_CMD[2];
              cs_nxt = 1'b1; // R3
            end
          end
        end
        ST_DONE: begin
          cs_nxt = 1'b0;
          cs_oe_n_nxt = 1'b0;
          di_nxt = 1'b0;
          sck_nxt = 1'b0;
        end
      endcase
    end
    // Status flags registered so the outputs come from flops
    done_nxt = (st_nxt == ST_DONE);
    busy_nxt = (st_nxt != ST_DONE);
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      st_r <= ST_SENSE;
      div_r <= 7'h00;
      sense_r <= 3'h0;
      bit_r <= 5'h00;
      addr_r <= ROM_ADDR_RST;
      cmd_r <= ROM_CMD_RST;
      data_r <= ROM_DATA_RST;
      sck_r <= 1'b0;
      sck_oe_n_r <= 1'b1;
      cs_r <= 1'b0;
      cs_oe_n_r <= 1'b1;
      di_r <= 1'b0;
      skip_r <= 1'b0;
      mrd_r <= 1'b0;
      mclk_r <= 1'b0;
      done_r <= 1'b0;
      busy_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      div_r <= div_nxt;
      sense_r <= sense_nxt;
      bit_r <= bit_nxt;
      addr_r <= addr_nxt;
      cmd_r <= cmd_nxt;
      data_r <= data_nxt;
      sck_r <= sck_nxt;
      sck_oe_n_r <= 1'b0;
      cs_r <= cs_nxt;
      cs_oe_n_r <= cs_oe_n_nxt;
      di_r <= di_nxt;
      skip_r <= skip_nxt;
      mrd_r <= rom_read_data_i; // R7
      mclk_r <= rom_serial_clock_i;
      done_r <= done_nxt;
      busy_r <= busy_nxt;
    end
  end

  rcel_buf #(
    .WIDTH($bits(rcel_word_s))
  ) u_buf (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_r),
    .in_valid_i(st_r == ST_PUSH && !manual_en_i && !soft_reset_i),
    .in_data_i(push_word),
    .in_ready_o(buf_ready),
    .out_valid_o(word_valid_o),
    .out_data_o(word_o),
    .out_ready_i(word_ready_i)
  );

  assign rom_serial_clock_o = sck_r;
  assign rom_serial_clock_oe_n_o = sck_oe_n_r;
  assign rom_chip_select_o = cs_r;
  assign rom_chip_select_oe_n_o = cs_oe_n_r;
  assign rom_write_data_o = di_r;
  assign manual_rdata_o = mrd_r;
  assign manual_clk_level_o = mclk_r;
  assign load_busy_o = busy_r;
  assign load_done_o = done_r;
  assign load_skipped_o = skip_r;
endmodule
`default_nettype wire

// ==== core/rcel_pkg.sv ====
// Constants and types shared by the configuration loader files
package rcel_pkg;
  // Serial clock divider: full period and half period in system clocks
  localparam int ROM_CLK_DIV = 256;
  localparam logic [6:0] ROM_HALF_LAST = 7'(ROM_CLK_DIV / 2 - 1);
  // Read frame: start bit, two opcode bits, six address bits, sixteen data bits
  localparam logic [2:0] ROM_READ_CMD = 3'h6;
  localparam logic [4:0] ROM_CMD_BITS = 5'h09;
  localparam logic [4:0] ROM_FRAME_LAST = 5'h18;
  localparam logic [5:0] ROM_LAST_ADDR = 6'h3F;
  // Cycles the chip-select pin is left released before its level is trusted
  localparam logic [2:0] ROM_SENSE_LAST = 3'h3;
  // Channel count and control bit positions
  localparam int UART_CHANNELS = 8;
  localparam int FEATURE_HALFDUPLEX_BIT = 5;
  localparam int MODEM_INFRARED_BIT = 6;
  // Reset values
  localparam logic [5:0] ROM_ADDR_RST = 6'h00;
  localparam logic [8:0] ROM_CMD_RST = 9'h000;
  localparam logic [15:0] ROM_DATA_RST = 16'h0000;

  typedef struct packed {
    logic [5:0] addr;
    logic [15:0] data;
  } rcel_word_s;

  typedef enum logic [4:0] {
    ST_SENSE = 5'h01,
    ST_SHIFT = 5'h02,
    ST_PUSH = 5'h04,
    ST_GAP = 5'h08,
    ST_DONE = 5'h10
  } rcel_state_e;
endpackage

// ==== core/rcel_buf.sv ====
// Two-entry buffer with registered output for loaded words
`timescale 1ns/1ps
`default_nettype none
module rcel_buf
  import rcel_pkg::*;
#(
  parameter int WIDTH = 22
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Filling side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // Draining side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  logic out_v_r, out_v_nxt, skid_v_r, skid_v_nxt;
  logic [WIDTH-1:0] out_r, out_nxt, skid_r, skid_nxt;

  // Skid slot catches the word accepted while the drain side stalls
  always_comb begin
    out_v_nxt = out_v_r;
    out_nxt = out_r;
    skid_v_nxt = skid_v_r;
    skid_nxt = skid_r;
    if (out_v_r && out_ready_i) begin
      out_v_nxt = skid_v_r;
      out_nxt = skid_r;
      skid_v_nxt = 1'b0;
    end
    if (in_valid_i && !skid_v_r) begin
      if (!out_v_nxt) begin
        out_v_nxt = 1'b1;
        out_nxt = in_data_i;
      end else begin
        skid_v_nxt = 1'b1;
        skid_nxt = in_data_i;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_v_r <= 1'b0;
      skid_v_r <= 1'b0;
      out_r <= '0;
      skid_r <= '0;
    end else begin
      out_v_r <= out_v_nxt;
      skid_v_r <= skid_v_nxt;
      out_r <= out_nxt;
      skid_r <= skid_nxt;
    end
  end

  assign in_ready_o = !skid_v_r;
  assign out_valid_o = out_v_r;
  assign out_data_o = out_r;
endmodule
`default_nettype wire

// ==== sim/rcel_rom_model.sv ====
// Serial configuration ROM model answering read frames
`timescale 1ns/1ps
`default_nettype none
module rcel_rom_model (
  input wire logic sck_i,
  input wire logic cs_i,
  input wire logic di_i,
  output logic do_o
);
  logic [4:0] cnt = 5'h00;
  logic [5:0] addr = 6'h00;
  logic [15:0] sh = 16'h0000;
  initial do_o = 1'b0;
  always @(posedge cs_i) cnt = 5'h00;
  always @(posedge sck_i) begin
    // Counting starts at the start bit, so clock edges out of reset are ignored
    if (cs_i && (cnt != 5'h00 || di_i === 1'b1)) begin
      if (cnt < 9) addr = {addr[4:0], di_i};
      cnt = cnt + 5'h01;
    end
  end
  // Line falls to its pull-down outside the data bits
  always @(negedge sck_i or negedge cs_i) begin
    if (cnt == 9) sh = {addr, 4'hA, ~addr};
    else sh = sh << 1;
    do_o = cs_i && cnt >= 9 && cnt < 25 && sh[15];
  end
endmodule
`default_nettype wire

// ==== sim/rcel_monitor.sv ====
// Port checker for the configuration loader
`timescale 1ns/1ps
`default_nettype none
module rcel_monitor
  import rcel_pkg::*;
(
  // Control side
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic soft_reset_i,
  input wire logic manual_en_i,
  input wire logic manual_clk_i,
  input wire logic manual_cs_i,
  input wire logic manual_wdata_i,
  input wire logic manual_rdata_o,
  // Pins and outputs
  input wire logic rom_serial_clock_o,
  input wire logic rom_chip_select_o,
  input wire logic rom_chip_select_oe_n_o,
  input wire logic rom_write_data_o,
  input wire logic rom_read_data_i,
  input wire logic auto_halfduplex_strap_n_i,
  input wire logic infrared_strap_n_i,
  input wire logic [UART_CHANNELS-1:0][7:0] uart_feature_control_o,
  input wire logic [UART_CHANNELS-1:0][7:0] uart_modem_control_o,
  input wire logic word_valid_o,
  input wire rcel_word_s word_o,
  input wire logic word_ready_i,
  input wire logic load_skipped_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  logic [8:0] hi_r;
  logic dis_r;
  // Manual or soft reset may cut a high phase short
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hi_r <= 9'h000;
      dis_r <= 1'b0;
    end else begin
      hi_r <= rom_serial_clock_o ? hi_r + 9'h001 : 9'h000;
      dis_r <= manual_en_i | soft_reset_i | (dis_r & rom_serial_clock_o);
    end
  end
  clk_half_a: assert property ($fell(rom_serial_clock_o) && !dis_r |-> hi_r == 9'h080)
    else $error("serial clock high phase wrong");
  man_clk_a: assert property (manual_en_i && $past(manual_en_i) |->
    rom_serial_clock_o == $past(manual_clk_i)) else $error("manual clock not followed");
  sel_frame_a: assert property ($rose(rom_serial_clock_o) && !manual_en_i |->
    rom_chip_select_o && !rom_chip_select_oe_n_o) else $error("clock without select");
  skip_sel_a: assert property (load_skipped_o && !manual_en_i && !$past(manual_en_i) |->
    !rom_chip_select_o) else $error("select after skip");
  man_sel_a: assert property (manual_en_i && $past(manual_en_i) |->
    rom_chip_select_o == $past(manual_cs_i) && !rom_chip_select_oe_n_o)
    else $error("manual select not followed");
  man_data_a: assert property (manual_en_i && $past(manual_en_i) |->
    rom_write_data_o == $past(manual_wdata_i)) else $error("manual data not followed");
  read_copy_a: assert property (manual_rdata_o == $past(rom_read_data_i))
    else $error("read copy wrong");
  feat_strap_a: assert property ($past(soft_reset_i, 2) |->
    uart_feature_control_o == {8{8'(!auto_halfduplex_strap_n_i) << 5}})
    else $error("feature strap wrong");
  ir_strap_a: assert property ($past(soft_reset_i, 2) |->
    uart_modem_control_o == {8{8'(!infrared_strap_n_i) << 6}}) else $error("modem strap wrong");
  word_hold_a: assert property (word_valid_o && !word_ready_i && !soft_reset_i |=>
    word_valid_o && $stable(word_o)) else $error("stalled word changed");
  cover property (load_skipped_o);
  cover property (word_valid_o && !word_ready_i);
  cover property (manual_en_i && manual_clk_i);
endmodule
bind rcel_top rcel_monitor u_mon (.*);
`default_nettype wire

// ==== sim/rcel_top_test.sv ====
// Testbench for the configuration loader
`timescale 1ns/1ps
`default_nettype none
module rcel_top_test;
  import rcel_pkg::*;
  logic clk_sys_i = 1'b0, reset_n_i = 1'b0, soft_reset_i = 1'b0, manual_en_i = 1'b0;
  logic manual_clk_i = 1'b0, manual_cs_i = 1'b0, manual_wdata_i = 1'b0, word_ready_i = 1'b0;
  logic auto_halfduplex_strap_n_i = 1'b0, infrared_strap_n_i = 1'b1, board_cs = 1'b1;
  wire logic manual_rdata_o, manual_clk_level_o, rom_serial_clock_o, rom_serial_clock_oe_n_o;
  wire logic rom_chip_select_o, rom_chip_select_oe_n_o, rom_write_data_o, rom_read_data_i;
  wire logic word_valid_o, load_busy_o, load_done_o, load_skipped_o;
  wire logic [UART_CHANNELS-1:0][7:0] uart_feature_control_o, uart_modem_control_o;
  rcel_word_s word_o;
  int failures = 0, cmp_count = 0;
  // Released clock pin has no pull, so it reads back inverted
  wire logic rom_serial_clock_i = rom_serial_clock_oe_n_o ? ~rom_serial_clock_o
    : rom_serial_clock_o;
  // Released select pin shows the board strap
  wire logic rom_chip_select_i = rom_chip_select_oe_n_o ? board_cs : rom_chip_select_o;
  always #20 clk_sys_i = ~clk_sys_i;
  rcel_top dut (.*);
  rcel_rom_model u_rom (.sck_i(rom_serial_clock_i), .cs_i(rom_chip_select_i),
    .di_i(rom_write_data_o), .do_o(rom_read_data_i));

  task automatic check(input string what, input logic [63:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic t_stall;
    int n;
    check("feature", uart_feature_control_o, {8{8'h20}});
    check("modem", uart_modem_control_o, 64'h0);
    for (n = 0; n < 9000 && !word_valid_o; n++) @(negedge clk_sys_i);
    // Long enough for two buffered words and a third held back
    repeat (20000) @(negedge clk_sys_i);
    check("held clock", rom_serial_clock_o, 1'b0);
    check("held select", rom_chip_select_o, 1'b1);
    check("held state", {rom_serial_clock_oe_n_o, load_busy_o, load_done_o}, 3'h2);
    word_ready_i = 1'b1;
    for (int a = 0; a < 3; a++) begin
      for (n = 0; n < 9000 && !word_valid_o; n++) @(negedge clk_sys_i);
      check("word", word_o, {6'(a), 6'(a), 4'hA, ~6'(a)});
      @(negedge clk_sys_i);
    end
    $display("stalled load done");
  endtask

  task automatic t_skip;
    int n;
    board_cs = 1'b0;
    auto_halfduplex_strap_n_i = 1'b1;
    infrared_strap_n_i = 1'b0;
    soft_reset_i = 1'b1;
    @(negedge clk_sys_i);
    soft_reset_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    check("feature", uart_feature_control_o, 64'h0);
    check("modem", uart_modem_control_o, {8{8'h40}});
    for (n = 0; n < 50 && !load_done_o; n++) @(negedge clk_sys_i);
    check("skip", {load_done_o, load_skipped_o, load_busy_o, rom_chip_select_o}, 4'hC);
    $display("skipped load done");
  endtask

  task automatic t_manual;
    logic [15:0] got;
    logic [8:0] cmd;
    got = 16'h0000;
    cmd = {ROM_READ_CMD, 6'h05};
    manual_en_i = 1'b1;
    manual_cs_i = 1'b1;
    for (int i = 0; i < 25; i++) begin
      manual_wdata_i = i < 9 ? cmd[8-i] : 1'b0;
      repeat (2) @(negedge clk_sys_i);
      manual_clk_i = 1'b1;
      repeat (2) @(negedge clk_sys_i);
      got = {got[14:0], manual_rdata_o};
      check("pins", {rom_serial_clock_o, rom_chip_select_o, rom_chip_select_oe_n_o,
        rom_write_data_o, manual_clk_level_o}, {3'h6, manual_wdata_i, 1'b1});
      manual_clk_i = 1'b0;
    end
    repeat (2) @(negedge clk_sys_i);
    manual_cs_i = 1'b0;
    check("manual word", got, {6'h05, 4'hA, ~6'h05});
    @(negedge clk_sys_i);
    manual_en_i = 1'b0;
    $display("manual read done");
  endtask

  initial begin
    repeat (80000) @(posedge clk_sys_i);
    failures++;
    report_and_stop();
  end

  initial begin
    repeat (20) @(negedge clk_sys_i);
    reset_n_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    t_stall();
    t_skip();
    t_manual();
    report_and_stop();
  end
endmodule
`default_nettype wire
